//--- hdl/sysctl_decoder.sv
// CPU-side executor of the system-control I/O instructions
// What this block does
// [RULE_01] Mask-out is broadcast, then the selected accumulator follows as priority mask.
// [RULE_02] Controllers set or clear interrupt-disable from their mask bit.
// [RULE_03] Mask-out, I/O reset, clock enable and disable update Interrupt On by code.
// [RULE_04] I/O reset acts on all controllers and on the CPU alike.
// [RULE_05] Controllers clear busy, done and interrupt-disable on I/O reset.
// [RULE_06] I/O reset stops the real-time clock raising interrupts.
// [RULE_07] Controllers ignore the data word after reset and clock instructions.
// [RULE_08] Halt stops instruction execution and leaves the CPU halted.
// [RULE_09] Halt forces Interrupt On to one.
// [RULE_10] While halted, program interrupts and data channel requests are still served.
// [RULE_11] Halt transfers no data word after the instruction.
// [RULE_12] CPU skip switches the CPU to I/O input mode.
// [RULE_13] No controller drives data in answer to CPU skip.
// [RULE_14] CPU skip tests Interrupt On by code; true adds one program count step.
// [RULE_15] Clock enable lets the real-time clock raise program interrupts.
// [RULE_16] Clock disable stops the real-time clock raising program interrupts.
// [RULE_17] Code 01 sets Interrupt On, 10 clears it, 11 leaves it.
// [RULE_18] Decode I/O class, all-ones device code, select by transfer field.
// [RULE_19] Flag updates apply after the data phase, before the next fetch.
`timescale 1ns/100ps
module sysctl_decoder
	import sysctl_pkg::*;
#(
	parameter int RTC_CYC = RTC_PERIOD_CYC
) (
	input wire logic clk, // System clock, 20 MHz
	input wire logic rst, // Synchronous reset, active high
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [7:0] wb_adr_i, // Wishbone byte address
	input wire logic [3:0] wb_sel_i, // Wishbone byte selects
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	output logic irq, // Level interrupt
	input wire logic prog_int_req, // Program interrupt request pin
	input wire logic dch_req, // Data channel request pin
	output logic [15:0] io_word, // Word sent to the I/O bus
	output logic io_word_valid, // One-cycle strobe for io_word
	output logic io_word_is_data, // io_word is the data phase
	output logic io_input_mode, // CPU listening on the I/O bus
	output logic io_reset_pulse, // Global I/O reset strobe
	output logic int_ack, // Program interrupt taken
	output logic dch_ack, // Data channel request taken
	output logic halted, // CPU in halted state
	output logic pc_skip // Extra program counter step
);

	// ---------------------------------------------
	// Register bus decode
	// ---------------------------------------------
	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire bus_wr = bus_req & wb_we_i;
	wire sel_instr = (wb_adr_i == OFS_INSTR);
	wire sel_ctrl = (wb_adr_i == OFS_CTRL);
	wire sel_status = (wb_adr_i == OFS_STATUS);
	wire sel_skip = (wb_adr_i == OFS_SKIP_CNT);
	wire sel_acc = (wb_adr_i[7:4] == OFS_ACC_BASE[7:4]) && (wb_adr_i[1:0] == 2'h0);
	wire sel_istat = (wb_adr_i == OFS_IRQ_STAT);
	wire sel_imask = (wb_adr_i == OFS_IRQ_MASK);
	wire [1:0] acc_idx = wb_adr_i[3:2];
	wire lo_wr = wb_sel_i[0];
	wire hi_wr = wb_sel_i[1];

	// ---------------------------------------------
	// State
	// ---------------------------------------------
	seq_state_t st_q, st_d;
	logic [15:0] instr_q;
	logic [15:0] acc_q [4];
	logic int_on_q;
	logic rtc_en_q;
	logic rtc_req_q;
	logic [15:0] skip_cnt_q;
	logic [EV_W-1:0] istat_q, imask_q, ev;
	logic [3:0] win_q;
	logic [2:0] pint_sync_q, dch_sync_q;
	logic pint_q, dch_q, dch_seen_q;
	logic rtc_tick;

	// ---------------------------------------------
	// Instruction field decode
	// ---------------------------------------------
	wire [2:0] f_class = instr_q[15:13];
	wire [1:0] f_acc = instr_q[12:11];
	wire [2:0] f_xfer = instr_q[10:8];
	wire [1:0] f_code = instr_q[7:6];
	wire [5:0] f_dev = instr_q[5:0];
	// [RULE_18] Class and device check
	wire is_cpu_io = (f_class == IO_CLASS) && (f_dev == CPU_DEV_CODE);
	wire is_mask_out = is_cpu_io && (f_xfer == XFER_MASK_OUT);
	wire is_io_reset = is_cpu_io && (f_xfer == XFER_IO_RESET);
	wire is_halt = is_cpu_io && (f_xfer == XFER_HALT);
	wire is_skip = is_cpu_io && (f_xfer == XFER_SKIP);
	wire is_rtc_en = is_cpu_io && (f_xfer == XFER_RTC) && (f_acc == RTC_SEL_ENABLE);
	wire is_rtc_dis = is_cpu_io && (f_xfer == XFER_RTC) && (f_acc == RTC_SEL_DISABLE);
	wire is_known = is_mask_out | is_io_reset | is_halt | is_skip | is_rtc_en | is_rtc_dis;
	// [RULE_11] Halt has no data phase
	wire has_data = is_mask_out | is_io_reset | is_rtc_en | is_rtc_dis;

	// [RULE_17] Interrupt On function codes
	function automatic logic fcode_apply(input logic cur, input logic [1:0] code);
		unique case (code)
			FCODE_SET: fcode_apply = 1'b1;
			FCODE_CLEAR: fcode_apply = 1'b0;
			default: fcode_apply = cur;
		endcase
	endfunction : fcode_apply

	// [RULE_14] Skip condition on Interrupt On
	function automatic logic skip_true(input logic on, input logic [1:0] code);
		skip_true = code[0] ? ~on : on;
	endfunction : skip_true

	wire launch = bus_wr && sel_instr && (st_q == ST_IDLE) && ~halted && lo_wr && hi_wr;
	wire refused = bus_wr && sel_instr && ~launch;
	wire win_done = (win_q == 4'(INPUT_WINDOW_CYC - 1));
	wire applying = (st_q == ST_APPLY);
	// [RULE_06] Disabled clock raises nothing
	wire pint_pending = pint_q | (rtc_req_q & rtc_en_q);
	// [RULE_10] Requests served even while halted
	wire take_int = (st_q == ST_IDLE) && int_on_q && pint_pending && ~int_ack;
	wire take_dch = (st_q == ST_IDLE) && dch_q && ~dch_seen_q;
	wire next_int_on = is_halt ? 1'b1 : (is_skip ? int_on_q : fcode_apply(int_on_q, f_code));

	// ---------------------------------------------
	// Sequencer
	// ---------------------------------------------
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE: begin
				if (launch) begin
					st_d = ST_SEND_INSTR;
				end
			end
			ST_SEND_INSTR: begin
				if (!is_known) begin
					st_d = ST_IDLE;
				end else if (has_data) begin
					st_d = ST_SEND_DATA;
				end else if (is_skip) begin
					st_d = ST_INPUT_WAIT;
				end else begin
					st_d = ST_APPLY;
				end
			end
			ST_SEND_DATA: begin
				st_d = ST_APPLY;
			end
			ST_INPUT_WAIT: begin
				if (win_done) begin
					st_d = ST_APPLY;
				end
			end
			ST_APPLY: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= ST_IDLE;
			win_q <= '0;
		end else begin
			st_q <= st_d;
			win_q <= (st_q == ST_INPUT_WAIT) ? win_q + 4'h1 : 4'h0;
		end
	end

	// ---------------------------------------------
	// I/O bus outputs
	// ---------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			io_word <= '0;
			io_word_valid <= 1'b0;
			io_word_is_data <= 1'b0;
			io_input_mode <= 1'b0;
			io_reset_pulse <= 1'b0;
		end else begin
			io_word_valid <= 1'b0;
			io_reset_pulse <= 1'b0;
			if (st_q == ST_SEND_INSTR && is_known) begin
				io_word <= instr_q;
				io_word_valid <= 1'b1;
				io_word_is_data <= 1'b0;
				// [RULE_04] Global reset strobe
				io_reset_pulse <= is_io_reset;
			end else if (st_q == ST_SEND_DATA) begin
				// [RULE_01] Accumulator follows as mask
				io_word <= acc_q[f_acc];
				io_word_valid <= 1'b1;
				io_word_is_data <= 1'b1;
			end
			// [RULE_12] Input mode during skip
			io_input_mode <= (st_d == ST_INPUT_WAIT);
		end
	end

	// ---------------------------------------------
	// CPU flags, applied after the data phase
	// ---------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			int_on_q <= 1'b0;
			rtc_en_q <= 1'b0;
			halted <= 1'b0;
			pc_skip <= 1'b0;
			skip_cnt_q <= '0;
		end else begin
			pc_skip <= 1'b0;
			// Resume first, so a halt entered in the same cycle wins
			if (bus_wr && sel_ctrl && lo_wr && wb_dat_i[CTRL_RESUME_BIT]) begin
				halted <= 1'b0;
			end
			if (applying) begin
				// [RULE_19] Update at instruction end
				// [RULE_03] Function code on Interrupt On
				// [RULE_09] Halt forces Interrupt On
				int_on_q <= next_int_on;
				// [RULE_06] Reset disables the clock
				// [RULE_16] Clock disable
				if (is_io_reset | is_rtc_dis) begin
					rtc_en_q <= 1'b0;
				// [RULE_15] Clock enable
				end else if (is_rtc_en) begin
					rtc_en_q <= 1'b1;
				end
				// [RULE_08] Enter halted state
				if (is_halt) begin
					halted <= 1'b1;
				end
				// [RULE_14] Extra program count step
				if (is_skip && skip_true(int_on_q, f_code)) begin
					pc_skip <= 1'b1;
					skip_cnt_q <= skip_cnt_q + 16'h1;
				end
			end else if (take_int) begin
				int_on_q <= 1'b0;
			end
		end
	end

	// ---------------------------------------------
	// Request synchronisers and service
	// ---------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			pint_sync_q <= '0;
			dch_sync_q <= '0;
			pint_q <= 1'b0;
			dch_q <= 1'b0;
			dch_seen_q <= 1'b0;
			int_ack <= 1'b0;
			dch_ack <= 1'b0;
			rtc_req_q <= 1'b0;
		end else begin
			pint_sync_q <= {pint_sync_q[1:0], prog_int_req};
			dch_sync_q <= {dch_sync_q[1:0], dch_req};
			if (pint_sync_q[1] == pint_sync_q[2]) begin
				pint_q <= pint_sync_q[2];
			end
			if (dch_sync_q[1] == dch_sync_q[2]) begin
				dch_q <= dch_sync_q[2];
			end
			int_ack <= take_int;
			dch_ack <= take_dch;
			dch_seen_q <= dch_q & (dch_seen_q | take_dch);
			if (take_int || !rtc_en_q) begin
				rtc_req_q <= 1'b0;
			end else if (rtc_tick) begin
				rtc_req_q <= 1'b1;
			end
		end
	end

	rtc_ticker #(
		.PERIOD_CYC(RTC_CYC)
	) u_rtc (
		.clk(clk),
		.rst(rst),
		.tick(rtc_tick)
	);

	// ---------------------------------------------
	// Software registers
	// ---------------------------------------------
	assign ev[EV_DONE] = applying;
	assign ev[EV_SKIP] = applying && is_skip && skip_true(int_on_q, f_code);
	assign ev[EV_HALT] = applying && is_halt;
	assign ev[EV_REFUSED] = refused || (st_q == ST_SEND_INSTR && !is_known);
	assign ev[EV_RTC] = rtc_tick && rtc_en_q;
	wire [EV_W-1:0] w1c = (bus_wr && sel_istat && lo_wr) ? wb_dat_i[EV_W-1:0] : '0;

	always_ff @(posedge clk) begin
		if (rst) begin
			instr_q <= '0;
			istat_q <= '0;
			imask_q <= IRQ_MASK_RST;
			irq <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				acc_q[i] <= ACC_RST;
			end
		end else begin
			if (launch) begin
				instr_q <= wb_dat_i[15:0];
			end
			if (bus_wr && sel_acc) begin
				if (lo_wr) begin
					acc_q[acc_idx][7:0] <= wb_dat_i[7:0];
				end
				if (hi_wr) begin
					acc_q[acc_idx][15:8] <= wb_dat_i[15:8];
				end
			end
			if (bus_wr && sel_imask && lo_wr) begin
				imask_q <= wb_dat_i[EV_W-1:0];
			end
			istat_q <= (istat_q & ~w1c) | ev;
			irq <= |(istat_q & imask_q);
		end
	end

	wire busy = (st_q != ST_IDLE);
	wire [31:0] rd_mux =
		sel_instr ? {16'h0000, instr_q} :
		sel_status ? {28'h0000000, busy, rtc_en_q, int_on_q, halted} :
		sel_skip ? {16'h0000, skip_cnt_q} :
		sel_acc ? {16'h0000, acc_q[acc_idx]} :
		sel_istat ? {27'h0000000, istat_q} :
		sel_imask ? {27'h0000000, imask_q} : 32'h00000000;

	always_ff @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= (bus_req && !wb_we_i) ? rd_mux : 32'h00000000;
		end
	end

endmodule : sysctl_decoder

//--- hdl/sysctl_pkg.sv
// Constants shared by the system-control instruction decoder
package sysctl_pkg;

	// ---------------------------------------------
	// Instruction fields, bit 15 is the word's MSB
	// ---------------------------------------------
	localparam logic [2:0] IO_CLASS = 3'h3;
	localparam logic [5:0] CPU_DEV_CODE = 6'h3f;
	localparam logic [2:0] XFER_MASK_OUT = 3'h4;
	localparam logic [2:0] XFER_IO_RESET = 3'h5;
	localparam logic [2:0] XFER_HALT = 3'h6;
	localparam logic [2:0] XFER_SKIP = 3'h7;
	localparam logic [2:0] XFER_RTC = 3'h2;
	localparam logic [1:0] RTC_SEL_ENABLE = 2'h2;
	localparam logic [1:0] RTC_SEL_DISABLE = 2'h1;
	localparam logic [1:0] FCODE_SET = 2'h1;
	localparam logic [1:0] FCODE_CLEAR = 2'h2;

	// ---------------------------------------------
	// Register byte offsets
	// ---------------------------------------------
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_SKIP_CNT = 8'h0c;
	localparam logic [7:0] OFS_ACC_BASE = 8'h10;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

	// ---------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------
	localparam int CTRL_RESUME_BIT = 0;
	localparam int EV_DONE = 0;
	localparam int EV_SKIP = 1;
	localparam int EV_HALT = 2;
	localparam int EV_REFUSED = 3;
	localparam int EV_RTC = 4;
	localparam int EV_W = 5;
	localparam logic [EV_W-1:0] IRQ_MASK_RST = 5'h00;
	localparam logic [15:0] ACC_RST = 16'h0000;

	// ---------------------------------------------
	// Timing
	// ---------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int INPUT_WINDOW_NS = 400;
	localparam int INPUT_WINDOW_CYC = (INPUT_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RTC_PERIOD_US = 1000;
	localparam int RTC_PERIOD_CYC = RTC_PERIOD_US * 1000 / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SEND_INSTR,
		ST_SEND_DATA,
		ST_INPUT_WAIT,
		ST_APPLY
	} seq_state_t;

endpackage : sysctl_pkg

//--- hdl/rtc_ticker.sv
// Real-time clock period divider producing one-cycle ticks
`timescale 1ns/100ps
module rtc_ticker #(
	parameter int PERIOD_CYC = 20000
) (
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset
	output logic tick // One-cycle tick each period
);

	localparam int CW = $clog2(PERIOD_CYC + 1);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	wire wrap = (cnt_q == CW'(PERIOD_CYC - 1));

	assign cnt_d = wrap ? '0 : cnt_q + CW'(1);

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick <= wrap;
		end
	end

endmodule : rtc_ticker

//--- dv/sysctl_props.sv
// Port-level checks of the system-control decoder
`timescale 1ns/100ps
module sysctl_props
	import sysctl_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic wb_cyc_i, // Cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_we_i, // Write
	input wire logic wb_ack_o, // Ack
	input wire logic [15:0] io_word, // Bus word
	input wire logic io_word_valid, // Word strobe
	input wire logic io_word_is_data, // Data phase
	input wire logic io_input_mode, // Input window
	input wire logic io_reset_pulse, // Reset strobe
	input wire logic halted // Halted
);
	// ------------------------------
	// Sequences
	// ------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence instr_s(logic [2:0] x);
		io_word_valid && !io_word_is_data && io_word[10:8] == x;
	endsequence
	sequence data_s;
		io_word_valid && io_word_is_data;
	endsequence
	ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	mask_data_a: assert property (instr_s(XFER_MASK_OUT) |=> data_s)
		else $error("mask word missing");
	reset_pair_a: assert property (io_reset_pulse |-> instr_s(XFER_IO_RESET) ##1 data_s)
		else $error("reset strobe misplaced");
	halt_nodata_a: assert property (instr_s(XFER_HALT) |=> !io_word_valid [*3])
		else $error("halt sent data");
	halt_enter_a: assert property (instr_s(XFER_HALT) |-> ##[0:6] halted)
		else $error("halt not entered");
	halt_hold_a: assert property (halted && !(wb_cyc_i && wb_we_i) |=> halted)
		else $error("halt left alone");
	skip_window_a: assert property (instr_s(XFER_SKIP) |-> io_input_mode [*8] ##1 !io_input_mode)
		else $error("skip input window wrong");
	skip_quiet_a: assert property (instr_s(XFER_SKIP) |=> !io_word_valid [*8])
		else $error("word during skip");
endmodule : sysctl_props

bind sysctl_decoder sysctl_props u_sysctl_props (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .io_word(io_word),
	.io_word_valid(io_word_valid), .io_word_is_data(io_word_is_data),
	.io_input_mode(io_input_mode), .io_reset_pulse(io_reset_pulse), .halted(halted));

//--- dv/io_ctrl_model.sv
// One I/O controller seen from the shared I/O bus
`timescale 1ns/100ps
module io_ctrl_model
	import sysctl_pkg::*;
#(
	parameter int PRIO = 5
) (
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic [15:0] io_word, // Word from CPU
	input wire logic io_word_valid, // Word strobe
	input wire logic io_word_is_data, // Data phase
	input wire logic io_reset_pulse, // Global reset
	input wire logic set_flags, // Bench sets busy and done
	output logic busy_q, // Busy
	output logic done_q, // Done
	output logic int_dis_q // Interrupt disable
);
	logic mask_next_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			int_dis_q <= 1'b0;
			mask_next_q <= 1'b0;
		end else if (io_reset_pulse) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			int_dis_q <= 1'b0;
			mask_next_q <= 1'b0;
		end else begin
			if (set_flags) begin
				busy_q <= 1'b1;
				done_q <= 1'b1;
			end
			if (io_word_valid && !io_word_is_data)
				mask_next_q <= io_word[10:8] == XFER_MASK_OUT;
			if (io_word_valid && io_word_is_data && mask_next_q)
				int_dis_q <= io_word[15-PRIO];
		end
	end
endmodule : io_ctrl_model

//--- dv/tb_top.sv
// Self-checking bench for the system-control decoder
`timescale 1ns/100ps
module tb_top;
	import sysctl_pkg::*;
	localparam int RTC = 20;
	localparam int PRIO = 5;
	logic clk = 0, rst = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0, pir = 0, dcr = 0, set_flags = 0;
	logic [7:0] wb_adr = 8'h00;
	logic [31:0] wb_dat = 32'h0, wb_dat_o, rd, r;
	logic wb_ack, irq, iov, iod, iom, iorp, int_ack, dch_ack, halted, pc_skip;
	logic busy_q, done_q, int_dis_q, exp_on, exp_dis, on;
	logic [15:0] io_word, last_data, d;
	int fails = 0, samples_checked = 0, n_int = 0, n_dch = 0, n_skip = 0, cyc_n = 0, seed = 60;
	int b, e;
	always #25 clk = ~clk;
	sysctl_decoder #(.RTC_CYC(RTC)) u_sysctl_decoder (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .irq(irq), .prog_int_req(pir), .dch_req(dcr),
		.io_word(io_word), .io_word_valid(iov), .io_word_is_data(iod), .io_input_mode(iom),
		.io_reset_pulse(iorp), .int_ack(int_ack), .dch_ack(dch_ack), .halted(halted),
		.pc_skip(pc_skip));
	io_ctrl_model #(.PRIO(PRIO)) u_io_ctrl_model (.clk(clk), .rst(rst), .io_word(io_word),
		.io_word_valid(iov), .io_word_is_data(iod), .io_reset_pulse(iorp),
		.set_flags(set_flags), .busy_q(busy_q), .done_q(done_q), .int_dis_q(int_dis_q));
	function automatic logic [15:0] ins(logic [1:0] a, logic [2:0] x, logic [1:0] c);
		return {IO_CLASS, a, x, c, CPU_DEV_CODE};
	endfunction : ins
	function automatic logic f_on(logic p, logic [1:0] c);
		return (c == FCODE_SET) ? 1'b1 : (c == FCODE_CLEAR) ? 1'b0 : p;
	endfunction : f_on
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			fails++;
		end
	endtask : chk
	task automatic wb(logic we, logic [7:0] a, logic [31:0] dw);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= dw;
		while (wb_ack !== 1'b1) begin
			@(posedge clk);
		end
		rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic run(logic [15:0] w);
		wb(1'b1, OFS_INSTR, {16'h0, w});
		rd = 32'h8;
		while (rd[3] !== 1'b0) begin
			wb(1'b0, OFS_STATUS, 32'h0);
		end
	endtask : run
	always @(posedge clk) begin
		if (int_ack === 1'b1) n_int <= n_int + 1;
		if (dch_ack === 1'b1) n_dch <= n_dch + 1;
		if (pc_skip === 1'b1) n_skip <= n_skip + 1;
		if (iov === 1'b1 && iod === 1'b1) last_data <= io_word;
		cyc_n <= cyc_n + 1;
		if (cyc_n == 20000) begin
			fails++;
			give_verdict();
		end
	end
	// ------------------------------
	// Scenarios
	// ------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		wb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, OFS_IRQ_MASK, 32'h0);
		chk(rd, {27'h0, IRQ_MASK_RST});
		wb(1'b1, 8'h40, 32'h5);
		wb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		$display("test reset done");
		exp_on = 1'b0;
		exp_dis = 1'b0;
		for (int k = 0; k < 12; k++) begin
			r = $random(seed);
			d = r[31:16];
			wb(1'b1, OFS_ACC_BASE + {4'h0, r[4:3], 2'h0}, {16'h0, d});
			set_flags <= 1'b1;
			@(posedge clk);
			set_flags <= 1'b0;
			case (r[1:0])
				2'h1: run(ins(r[4:3], XFER_IO_RESET, r[6:5]));
				2'h2: run(ins(RTC_SEL_DISABLE, XFER_RTC, r[6:5]));
				default: run(ins(r[4:3], XFER_MASK_OUT, r[6:5]));
			endcase
			exp_on = f_on(exp_on, r[6:5]);
			if (r[1:0] == 2'h1) exp_dis = 1'b0;
			else if (r[1:0] != 2'h2) exp_dis = d[15-PRIO];
			wb(1'b0, OFS_STATUS, 32'h0);
			chk(rd, {30'h0, exp_on, 1'b0});
			chk({29'h0, busy_q, done_q, int_dis_q}, {29'h0, {2{r[1:0] != 2'h1}}, exp_dis});
			if (r[1:0] != 2'h2) chk({16'h0, last_data}, {16'h0, d});
		end
		$display("test random ops done");
		b = n_int;
		run(ins(RTC_SEL_ENABLE, XFER_RTC, FCODE_SET));
		repeat (3 * RTC) @(posedge clk);
		chk(n_int, b + 1);
		b = n_int;
		run(ins(RTC_SEL_DISABLE, XFER_RTC, FCODE_SET));
		repeat (3 * RTC) @(posedge clk);
		chk(n_int, b);
		run(ins(RTC_SEL_ENABLE, XFER_RTC, FCODE_CLEAR));
		run(ins(2'h0, XFER_IO_RESET, FCODE_SET));
		repeat (3 * RTC) @(posedge clk);
		chk(n_int, b);
		wb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h2);
		$display("test clock done");
		run(ins(2'h0, XFER_MASK_OUT, FCODE_CLEAR));
		run(ins(2'h0, XFER_HALT, FCODE_CLEAR));
		wb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h3);
		b = n_int;
		pir <= 1'b1;
		for (int i = 0; i < 20 && n_int == b; i++) @(posedge clk);
		pir <= 1'b0;
		chk(n_int, b + 1);
		dcr <= 1'b1;
		for (int i = 0; i < 20 && n_dch == 0; i++) @(posedge clk);
		dcr <= 1'b0;
		chk(n_dch, 1);
		wb(1'b1, OFS_INSTR, {16'h0, ins(2'h0, XFER_SKIP, 2'h0)});
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		wb(1'b1, OFS_IRQ_MASK, 32'h8);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		wb(1'b1, OFS_IRQ_STAT, 32'h8);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		wb(1'b1, OFS_IRQ_MASK, 32'h0);
		wb(1'b1, OFS_CTRL, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, halted}, 32'h0);
		$display("test halt done");
		e = 0;
		for (int k = 0; k < 8; k++) begin
			on = k[2];
			run(ins(2'h0, XFER_MASK_OUT, on ? FCODE_SET : FCODE_CLEAR));
			b = n_skip;
			run(ins(2'h0, XFER_SKIP, k[1:0]));
			repeat (4) @(posedge clk);
			if (k[0] ? !on : on) e++;
			chk(n_skip, b + ((k[0] ? !on : on) ? 1 : 0));
		end
		wb(1'b0, OFS_SKIP_CNT, 32'h0);
		chk(rd, e);
		$display("test skip done");
		wb(1'b1, OFS_IRQ_STAT, 32'h1f);
		run(ins(2'h0, XFER_MASK_OUT, FCODE_SET) ^ 16'h0001);
		wb(1'b0, OFS_IRQ_STAT, 32'h0);
		chk(rd & 32'h9, 32'h8);
		$display("test decode done");
		give_verdict();
	end
endmodule : tb_top
